/* File: dialer_pkg.sv */
// constants, formats, message layout and states of the alarm dialer sequencer
// assumes a single 25 MHz core clock and a synchronous active-high reset
package dialer_pkg;
	localparam int          CLK_HZ         = 25_000_000;
	localparam int          MS_PER_S       = 1000;
	localparam int          S_PER_MIN      = 60;
	localparam int          ONHOOK_S       = 3;
	localparam int          HANDSHAKE_S    = 40;
	localparam int          PULSE_BREAK_MS = 60;
	localparam int          PULSE_MAKE_MS  = 40;
	localparam int          INTERDIGIT_MS  = 700;
	localparam int          TONE_ON_MS     = 100;
	localparam int          TONE_OFF_MS    = 100;
	localparam int          FLASH_MS       = 125;
	localparam int          PREFER_TRIES   = 2;
	localparam int          NUM_DIGITS     = 16;
	localparam logic [3:0]  END_DIGIT      = 4'hF;
	localparam logic [7:0]  CR_CHAR        = 8'h0D;
	localparam logic [7:0]  SPACE_CHAR     = 8'h20;
	localparam logic [5:0]  LEN_THREE_ONE  = 6'h04;
	localparam logic [5:0]  LEN_FOUR_TWO   = 6'h06;
	localparam logic [5:0]  LEN_EVENT      = 6'h08;
	localparam logic [5:0]  LEN_TEXT       = 6'h06;
	localparam logic [5:0]  LEN_PAGE       = 6'h3C;
	localparam logic [11:0] TEST_NORMAL    = 12'h602;
	localparam logic [11:0] TEST_ABNORMAL  = 12'h608;
	localparam logic [3:0]  TEST_PRIO      = 4'h0;

	typedef enum logic [2:0] {
		FMT_EVENT     = 3'h0,
		FMT_TEXT      = 3'h1,
		FMT_THREE_ONE = 3'h2,
		FMT_FOUR_TWO  = 3'h3,
		FMT_PAGE      = 3'h4
	} format_type;

	typedef struct packed {
		logic [3:0]  prio;
		logic [11:0] code;
		logic [7:0]  part;
		logic [11:0] unit;
	} msg_type;

	typedef enum logic [9:0] {
		ST_IDLE      = 10'h001,
		ST_SEIZE     = 10'h002,
		ST_DIALTONE  = 10'h004,
		ST_DIAL      = 10'h008,
		ST_HANDSHAKE = 10'h010,
		ST_SEND      = 10'h020,
		ST_WAITACK   = 10'h040,
		ST_SHUTDOWN  = 10'h080,
		ST_BACKOFF   = 10'h100,
		ST_EXHAUSTED = 10'h200
	} state_type;

	typedef enum logic [3:0] {
		DG_IDLE  = 4'h1,
		DG_BREAK = 4'h2,
		DG_MAKE  = 4'h4,
		DG_GAP   = 4'h8
	} dig_state_type;
endpackage

/* File: digit_if.sv */
// handshake between the call sequencer and the digit signalling generator
// assumes both ends on core_clk
`timescale 1ns/1ps
`default_nettype none
interface digit_if;
	logic       start;
	logic [3:0] digit;
	logic       pulseMode;
	logic       msTick;
	logic       busy;
	logic       pulseBreak;
	logic       toneOn;
	logic [3:0] toneDigit;
	modport seq (output start, digit, pulseMode, msTick,
		input busy, pulseBreak, toneOn, toneDigit);
	modport gen (input start, digit, pulseMode, msTick,
		output busy, pulseBreak, toneOn, toneDigit);
endinterface
`default_nettype wire

/* File: digit_gen.sv */
// one-digit pulse or tone signalling generator
// assumes a millisecond tick from the sequencer
`timescale 1ns/1ps
`default_nettype none
module digit_gen (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// sequencer side
	digit_if.gen      dg
);
	dialer_pkg::dig_state_type state;
	logic [9:0] msCnt;
	logic [3:0] left;
	wire        isPulse  = (state == dialer_pkg::DG_BREAK) || (state == dialer_pkg::DG_MAKE);
	wire [9:0]  phaseLen = (state == dialer_pkg::DG_BREAK) ? 10'(dialer_pkg::PULSE_BREAK_MS) :
		(state == dialer_pkg::DG_MAKE) ? 10'(dialer_pkg::PULSE_MAKE_MS) :
		dg.toneOn ? 10'(dialer_pkg::TONE_ON_MS) :
		dg.pulseMode ? 10'(dialer_pkg::INTERDIGIT_MS) : 10'(dialer_pkg::TONE_OFF_MS);
	wire        phaseEnd = dg.msTick && (msCnt + 10'h001 >= phaseLen);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state         <= dialer_pkg::DG_IDLE;
			msCnt         <= 10'h000;
			left          <= 4'h0;
			dg.busy       <= 1'b0;
			dg.pulseBreak <= 1'b0;
			dg.toneOn     <= 1'b0;
			dg.toneDigit  <= 4'h0;
		end else begin
			msCnt <= phaseEnd ? 10'h000 : (dg.msTick ? msCnt + 10'h001 : msCnt);
			case (state)
				dialer_pkg::DG_IDLE: begin
					if (dg.start) begin
						dg.busy      <= 1'b1;
						msCnt        <= 10'h000;
						left         <= (dg.digit == 4'h0) ? 4'hA : dg.digit;
						dg.toneDigit <= dg.digit;
						dg.pulseBreak <= dg.pulseMode;
						dg.toneOn     <= !dg.pulseMode;
						state <= dg.pulseMode ? dialer_pkg::DG_BREAK : dialer_pkg::DG_GAP;
					end
				end
				dialer_pkg::DG_BREAK: begin
					if (phaseEnd) begin
						dg.pulseBreak <= 1'b0;
						left          <= left - 4'h1;
						state         <= dialer_pkg::DG_MAKE;
					end
				end
				dialer_pkg::DG_MAKE: begin
					if (phaseEnd) begin
						dg.pulseBreak <= (left != 4'h0);
						state <= (left != 4'h0) ? dialer_pkg::DG_BREAK : dialer_pkg::DG_GAP;
					end
				end
				default: begin
					if (phaseEnd && dg.toneOn)
						dg.toneOn <= 1'b0;
					else if (phaseEnd) begin
						dg.busy <= 1'b0;
						state   <= dialer_pkg::DG_IDLE;
					end
				end
			endcase
			if (isPulse && dg.toneOn)
				dg.toneOn <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: prio_buffer.sv */
// two-entry message buffer; read side always offers the higher priority entry
// assumes writer and reader on core_clk
`timescale 1ns/1ps
`default_nettype none
module prio_buffer #(
	parameter int WIDTH = 36,
	parameter int PRIO_W = 4
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	initial begin
		if (PRIO_W > WIDTH) $error("priority field wider than entry");
	end
	logic [WIDTH-1:0] slot [2];
	logic [1:0]       used;
	wire pickOne  = used[1] && (!used[0] ||
		slot[1][WIDTH-1 -: PRIO_W] > slot[0][WIDTH-1 -: PRIO_W]);
	wire doWrite  = inValid && inReady;
	wire doRead   = outValid && outReady;
	wire writeOne = used[0] && !(doRead && !pickOne);
	wire [1:0] clr = doRead ? (pickOne ? 2'b10 : 2'b01) : 2'b00;
	wire [1:0] set = doWrite ? (writeOne ? 2'b10 : 2'b01) : 2'b00;
	wire [1:0] next_used = (used & ~clr) | set;
	assign outValid = |used;
	assign outData  = pickOne ? slot[1] : slot[0];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			used    <= 2'b00;
			inReady <= 1'b0;
		end else begin
			used    <= next_used;
			inReady <= !(&next_used);
		end
		if (doWrite)
			slot[writeOne ? 1 : 0] <= inData;
	end
endmodule
`default_nettype wire

/* File: alarm_dialer_sequencer.sv */
// call sequencer: line seizure, dialing, handshake, message sending, retries
// assumes line sense pins asynchronous; modem and host on core_clk
`timescale 1ns/1ps
`default_nettype none
module alarm_dialer_sequencer #(
	parameter int MS_CYCLES = dialer_pkg::CLK_HZ / dialer_pkg::MS_PER_S
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// configuration
	input  wire logic        twoLines,
	input  wire logic        pulseDial,
	input  wire logic        blindDial,
	input  wire logic [2:0]  txFormat,
	input  wire logic [7:0]  maxAttempts,
	input  wire logic [7:0]  dialToneSec,
	input  wire logic [15:0] waitSec,
	input  wire logic [16:0] testMinutes,
	input  wire logic [3:0]  abnormalMask,
	input  wire logic [15:0] accountNum,
	input  wire logic [7:0]  userId,
	input  wire logic        accountEnable,
	input  wire logic [63:0] primaryNumber,
	input  wire logic [63:0] secondaryNumber,
	// system state from host
	input  wire logic [3:0]  systemState,
	// event messages from host
	input  wire logic        eventValid,
	output logic             eventReady,
	input  wire logic [35:0] eventData,
	// line sense pins
	input  wire logic [1:0]  lineInUse,
	input  wire logic [1:0]  lineVoltage,
	input  wire logic        dialTone,
	// modem side
	input  wire logic        handshake,
	input  wire logic [2:0]  handshakeFormat,
	input  wire logic        msgAck,
	input  wire logic        shutdown,
	output logic             txValid,
	input  wire logic        txReady,
	output logic [7:0]       txData,
	// line drive
	output logic [1:0]       offHook,
	output logic             toneOn,
	output logic [3:0]       toneDigit,
	// indicators and status
	output logic             line_one_indicator,
	output logic             line_two_indicator,
	output logic             trouble,
	output logic [1:0]       lineFault,
	output logic             callActive
);
	initial begin
		if (MS_CYCLES < 1) $error("MS_CYCLES must be at least one");
	end

	// ==============================================
	// input synchronisers
	logic [4:0] syncA;
	logic [4:0] syncB;
	always_ff @(posedge core_clk) begin
		syncA <= {dialTone, lineVoltage, lineInUse};
		syncB <= syncA;
	end
	wire       toneS  = syncB[4];
	wire [1:0] voltS  = syncB[3:2];
	wire [1:0] inUseS = syncB[1:0];

	// ==============================================
	// time base
	logic [$clog2(MS_CYCLES+1)-1:0] cycCnt;
	logic [9:0]  msCnt;
	logic [5:0]  secOfMin;
	logic [6:0]  flashCnt;
	logic        flash;
	logic        msTick;
	logic        secTick;
	logic [15:0] secs;
	logic [16:0] minCnt;
	wire msWrap  = (cycCnt == ($bits(cycCnt))'(MS_CYCLES - 1));
	wire secWrap = msWrap && (msCnt == 10'(dialer_pkg::MS_PER_S - 1));
	wire minWrap = secWrap && (secOfMin == 6'(dialer_pkg::S_PER_MIN - 1));
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cycCnt   <= '0;
			msCnt    <= 10'h000;
			secOfMin <= 6'h00;
			flashCnt <= 7'h00;
			flash    <= 1'b0;
			msTick   <= 1'b0;
			secTick  <= 1'b0;
		end else begin
			cycCnt   <= msWrap ? '0 : cycCnt + 1'b1;
			msCnt    <= secWrap ? 10'h000 : (msWrap ? msCnt + 10'h001 : msCnt);
			secOfMin <= minWrap ? 6'h00 : (secWrap ? secOfMin + 6'h01 : secOfMin);
			msTick   <= msWrap;
			secTick  <= secWrap;
			if (msWrap) begin
				flashCnt <= (flashCnt == 7'(dialer_pkg::FLASH_MS - 1)) ? 7'h00 : flashCnt + 7'h01;
				if (flashCnt == 7'(dialer_pkg::FLASH_MS - 1))
					flash <= !flash;
			end
		end
	end

	// ==============================================
	// periodic test message
	logic testPending;
	wire abnormal = |(systemState & abnormalMask);
	wire [35:0] testMsg = {dialer_pkg::TEST_PRIO,
		abnormal ? dialer_pkg::TEST_ABNORMAL : dialer_pkg::TEST_NORMAL, 8'h00, 12'h000};
	wire hostIn = eventValid && accountEnable;
	wire bufInValid = hostIn || testPending;
	wire bufReady;
	wire newEvent = hostIn && bufReady;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			minCnt      <= 17'h00000;
			testPending <= 1'b0;
		end else begin
			if (minWrap && testMinutes != 17'h00000) begin
				minCnt <= (minCnt + 17'h00001 >= testMinutes) ? 17'h00000 : minCnt + 17'h00001;
				if (minCnt + 17'h00001 >= testMinutes)
					testPending <= 1'b1;
			end else if (testPending && !hostIn && bufReady)
				testPending <= 1'b0;
		end
	end

	// ==============================================
	// message buffer
	logic  popMsg;
	wire   msgValid;
	wire [35:0] msgRaw;
	prio_buffer #(.WIDTH(36), .PRIO_W(4)) queue (
		.core_clk (core_clk),
		.rst      (rst),
		.inValid  (bufInValid),
		.inReady  (bufReady),
		.inData   (hostIn ? eventData : testMsg),
		.outValid (msgValid),
		.outReady (popMsg),
		.outData  (msgRaw)
	);
	dialer_pkg::msg_type msg;
	assign msg = msgRaw;

	// ==============================================
	// digit generator
	digit_if dg ();
	digit_gen digits (
		.core_clk (core_clk),
		.rst      (rst),
		.dg       (dg.gen)
	);
	assign dg.msTick    = msTick;
	assign dg.pulseMode = pulseDial;

	// ==============================================
	// message symbols
	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
	endfunction
	logic [5:0] symIdx;
	wire  [2:0] fmt = txFormat;
	wire  [5:0] msgLen = (fmt == dialer_pkg::FMT_THREE_ONE) ? dialer_pkg::LEN_THREE_ONE :
		(fmt == dialer_pkg::FMT_FOUR_TWO) ? dialer_pkg::LEN_FOUR_TWO :
		(fmt == dialer_pkg::FMT_PAGE) ? dialer_pkg::LEN_PAGE :
		(fmt == dialer_pkg::FMT_TEXT) ? dialer_pkg::LEN_TEXT : dialer_pkg::LEN_EVENT;
	wire [31:0] eventSyms = {msg.code, msg.part, msg.unit};
	wire [23:0] textSyms  = {msg.code, msg.unit};
	wire [23:0] pageSyms  = {msg.code, msg.unit};
	wire [3:0]  evNib   = eventSyms[5'(7 - symIdx[2:0]) * 4 +: 4];
	wire [3:0]  txNib   = textSyms[5'(5 - symIdx[2:0]) * 4 +: 4];
	wire [3:0]  pgNib   = (symIdx < 6'h09) ? pageSyms[5'(8 - symIdx) * 4 +: 4] : 4'h0;
	wire [3:0]  acctNib = accountNum[5'(3 - symIdx[1:0]) * 4 +: 4];
	wire [7:0]  symbol =
		(fmt == dialer_pkg::FMT_THREE_ONE) ?
			hexc((symIdx == 6'h03) ? msg.code[3:0] : accountNum[5'(2 - symIdx[1:0]) * 4 +: 4]) :
		(fmt == dialer_pkg::FMT_FOUR_TWO) ?
			hexc((symIdx == 6'h04) ? msg.code[7:4] : (symIdx == 6'h05) ? msg.code[3:0] : acctNib) :
		(fmt == dialer_pkg::FMT_PAGE) ?
			((symIdx < 6'h02) ? hexc(symIdx[0] ? userId[3:0] : userId[7:4]) :
			(symIdx == 6'h02) ? dialer_pkg::CR_CHAR :
			(symIdx < 6'h09) ? hexc(pgNib) : dialer_pkg::SPACE_CHAR) :
		(fmt == dialer_pkg::FMT_TEXT) ? hexc(txNib) :
		hexc(evNib);

	// ==============================================
	// call sequencer
	dialer_pkg::state_type state;
	logic [7:0] attempts;
	logic       lineSel;
	logic       startLine;
	logic       singleShot;
	logic [3:0] digIdx;
	logic       digLaunched;
	logic       offHookCmd;
	wire  [6:0] pair = attempts[7:1];
	wire        numSel = twoLines ? pair[1] : attempts[2];
	wire [63:0] number = numSel ? secondaryNumber : primaryNumber;
	wire  [3:0] curDigit = number[63 - 4 * digIdx -: 4];
	wire        preferLine = twoLines && inUseS[0] && !inUseS[1];
	wire        nextLine = !twoLines ? 1'b0 :
		(attempts < 8'(dialer_pkg::PREFER_TRIES)) ? preferLine : startLine ^ pair[0];
	wire        lastTry = singleShot || (attempts + 8'h01 >= maxAttempts);
	wire        hsMatch = handshake && (handshakeFormat == txFormat);
	wire        digDone = digLaunched && !dg.busy && !dg.start;
	wire        txFire = txValid && txReady;
	logic       fail;
	always_comb begin
		fail = 1'b0;
		if (state == dialer_pkg::ST_DIALTONE && secTick && secs + 16'h0001 >= {8'h00, dialToneSec})
			fail = 1'b1;
		if ((state == dialer_pkg::ST_HANDSHAKE || state == dialer_pkg::ST_WAITACK) && secTick &&
			secs + 16'h0001 >= 16'(dialer_pkg::HANDSHAKE_S))
			fail = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state       <= dialer_pkg::ST_IDLE;
			attempts    <= 8'h00;
			lineSel     <= 1'b0;
			startLine   <= 1'b0;
			singleShot  <= 1'b0;
			secs        <= 16'h0000;
			digIdx      <= 4'h0;
			digLaunched <= 1'b0;
			dg.start    <= 1'b0;
			dg.digit    <= 4'h0;
			offHookCmd  <= 1'b0;
			symIdx      <= 6'h00;
			txValid     <= 1'b0;
			txData      <= 8'h00;
			popMsg      <= 1'b0;
			trouble     <= 1'b0;
		end else begin
			secs     <= secTick ? secs + 16'h0001 : secs;
			dg.start <= 1'b0;
			popMsg   <= 1'b0;
			trouble  <= 1'b0;
			if (fail) begin
				offHookCmd <= 1'b0;
				secs       <= 16'h0000;
				txValid    <= 1'b0;
				attempts   <= lastTry ? attempts : attempts + 8'h01;
				singleShot <= 1'b0;
				trouble    <= lastTry && !singleShot;
				state      <= lastTry ? dialer_pkg::ST_EXHAUSTED : dialer_pkg::ST_BACKOFF;
			end else case (state)
				dialer_pkg::ST_IDLE: begin
					if (msgValid) begin
						lineSel   <= nextLine;
						startLine <= nextLine;
						secs      <= 16'h0000;
						state     <= dialer_pkg::ST_SEIZE;
					end
				end
				dialer_pkg::ST_SEIZE: begin
					if (secTick && secs >= 16'(dialer_pkg::ONHOOK_S)) begin
						offHookCmd  <= 1'b1;
						secs        <= 16'h0000;
						digIdx      <= 4'h0;
						digLaunched <= 1'b0;
						state <= blindDial ? dialer_pkg::ST_DIAL : dialer_pkg::ST_DIALTONE;
					end
				end
				dialer_pkg::ST_DIALTONE: begin
					if (toneS)
						state <= dialer_pkg::ST_DIAL;
				end
				dialer_pkg::ST_DIAL: begin
					if (!digLaunched && curDigit != dialer_pkg::END_DIGIT) begin
						dg.start    <= 1'b1;
						dg.digit    <= curDigit;
						digLaunched <= 1'b1;
					end else if (!digLaunched || digDone) begin
						digLaunched <= 1'b0;
						digIdx      <= digIdx + 4'h1;
						if (!digLaunched || digIdx == 4'(dialer_pkg::NUM_DIGITS - 1)) begin
							secs  <= 16'h0000;
							state <= dialer_pkg::ST_HANDSHAKE;
						end
					end
				end
				dialer_pkg::ST_HANDSHAKE: begin
					if (hsMatch) begin
						symIdx <= 6'h00;
						state  <= dialer_pkg::ST_SEND;
					end
				end
				dialer_pkg::ST_SEND: begin
					if (!txValid && msgValid) begin
						txValid <= 1'b1;
						txData  <= symbol;
					end else if (txFire) begin
						txValid <= 1'b0;
						symIdx  <= symIdx + 6'h01;
						if (symIdx + 6'h01 >= msgLen) begin
							secs  <= 16'h0000;
							state <= dialer_pkg::ST_WAITACK;
						end
					end else if (!txValid)
						state <= dialer_pkg::ST_SHUTDOWN;
				end
				dialer_pkg::ST_WAITACK: begin
					if (msgAck && !popMsg) begin
						popMsg <= 1'b1;
						symIdx <= 6'h00;
						secs   <= 16'h0000;
					end else if (popMsg)
						state <= dialer_pkg::ST_SEND;
				end
				dialer_pkg::ST_SHUTDOWN: begin
					if (shutdown) begin
						offHookCmd <= 1'b0;
						attempts   <= 8'h00;
						singleShot <= 1'b0;
						lineSel    <= 1'b0;
						state      <= dialer_pkg::ST_IDLE;
					end
				end
				dialer_pkg::ST_BACKOFF: begin
					if (secTick && secs + 16'h0001 >= waitSec) begin
						lineSel <= nextLine;
						secs    <= 16'h0000;
						state   <= dialer_pkg::ST_SEIZE;
					end
				end
				default: begin
					// new event restarts, each timer expiry retries one single attempt
					if (newEvent) begin
						attempts <= 8'h00;
						state    <= dialer_pkg::ST_IDLE;
					end else if (secTick && secs + 16'h0001 >= waitSec) begin
						singleShot <= 1'b1;
						lineSel    <= nextLine;
						secs       <= 16'h0000;
						state      <= dialer_pkg::ST_SEIZE;
					end
				end
			endcase
		end
	end

	// ==============================================
	// registered line drive, indicators, supervision
	wire lit    = offHookCmd && (state != dialer_pkg::ST_SEND) && (state != dialer_pkg::ST_WAITACK);
	wire indOn  = lit || (offHookCmd && flash);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			offHook            <= 2'b00;
			toneOn             <= 1'b0;
			toneDigit          <= 4'h0;
			line_one_indicator <= 1'b0;
			line_two_indicator <= 1'b0;
			lineFault          <= 2'b00;
			callActive         <= 1'b0;
			eventReady         <= 1'b0;
		end else begin
			offHook[0] <= offHookCmd && !lineSel && !dg.pulseBreak;
			offHook[1] <= offHookCmd && lineSel && !dg.pulseBreak;
			toneOn     <= dg.toneOn;
			toneDigit  <= dg.toneDigit;
			line_one_indicator <= indOn && !lineSel;
			line_two_indicator <= indOn && lineSel;
			lineFault[0] <= !voltS[0] && !(offHookCmd && !lineSel);
			lineFault[1] <= twoLines && !voltS[1] && !(offHookCmd && lineSel);
			callActive <= (state != dialer_pkg::ST_IDLE) && (state != dialer_pkg::ST_EXHAUSTED);
			eventReady <= bufReady;
		end
	end
endmodule
`default_nettype wire

/* File: dialer_asserts.sv */
// checker on the call sequencer top ports
// assumes binding below and MS_CYCLES handed on
`timescale 1ns/1ps
`default_nettype none
module dialer_asserts #(parameter int MS_CYCLES = 10) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// watched ports
	input wire logic       twoLines,
	input wire logic       txReady,
	input wire logic       txValid,
	input wire logic [7:0] txData,
	input wire logic [1:0] offHook,
	input wire logic       line_one_indicator,
	input wire logic       line_two_indicator,
	input wire logic       trouble,
	input wire logic       callActive
);
	// ========================================
	// on-hook run length within a call
	int holdCnt;
	always_ff @(posedge core_clk) begin
		if (rst || |offHook || !callActive) begin
			holdCnt <= 0;
		end else begin
			holdCnt <= holdCnt + 1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	seize_hold_a: assert property (
		$rose(|offHook) |-> holdCnt < 1000 * MS_CYCLES || holdCnt >= 3000 * MS_CYCLES)
		else $error("line seized too early");
	one_line_a: assert property (!twoLines |-> !offHook[1])
		else $error("second line used");
	ind_off_a: assert property (!callActive && !$past(callActive) |->
		!line_one_indicator && !line_two_indicator && offHook == 2'h0) else $error("left lit");
	ind_on_a: assert property (
		$rose(offHook[0]) && holdCnt >= 3000 * MS_CYCLES |-> ##[1:3] line_one_indicator)
		else $error("indicator dark");
	trouble_pulse_a: assert property (trouble |=> !trouble)
		else $error("trouble too long");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("symbol dropped");
	tx_gap_a: assert property (txValid && txReady |=> !txValid)
		else $error("no symbol gap");
	tx_call_a: assert property (txValid |-> callActive && offHook != 2'h0)
		else $error("send off call");
endmodule
bind alarm_dialer_sequencer dialer_asserts #(.MS_CYCLES(MS_CYCLES)) u_dialer_asserts (.*);
`default_nettype wire

/* File: station_model.sv */
// receiver model: dial tone, handshake, acks, shutdown
// assumes tone dialing and a two-digit number
`timescale 1ns/1ps
`default_nettype none
module station_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// scenario control
	input  wire logic       answer,
	input  wire logic [2:0] fmt,
	// line side
	input  wire logic [1:0] offHook,
	input  wire logic       toneOn,
	input  wire logic       txValid,
	output logic            dialTone,
	output logic            handshake,
	output logic [2:0]      handshakeFormat,
	output logic            msgAck,
	output logic            shutdown,
	output var logic        txReady
);
	// ========================================
	int   tones;
	int   syms;
	int   msgs;
	logic toneWas;
	assign dialTone = answer && |offHook;
	assign handshake = answer && tones >= 2 && |offHook;
	assign handshakeFormat = fmt;
	assign shutdown = msgs >= 2 && |offHook;
	always @(posedge core_clk) begin
		toneWas <= toneOn;
		txReady <= !txReady && !rst;
		msgAck <= 1'b0;
		if (rst || offHook == 2'h0) begin
			tones <= 0;
			syms <= 0;
			msgs <= 0;
		end else begin
			if (toneOn && !toneWas) tones <= tones + 1;
			if (txValid && txReady) begin
				syms <= (syms == 3) ? 0 : syms + 1;
				msgs <= msgs + ((syms == 3) ? 1 : 0);
				msgAck <= syms == 3;
			end
		end
	end
endmodule
`default_nettype wire

/* File: alarm_dialer_sequencer_test.sv */
// self-checking bench for the call sequencer
// assumes the station model on the line side
`timescale 1ns/1ps
`default_nettype none
module alarm_dialer_sequencer_test;
	// ========================================
	localparam int MS = 2;
	logic core_clk, rst, twoLines, answer, eventValid, eventReady, txValid, txReady;
	logic dialTone, handshake, msgAck, shutdown, toneOn, ind1, ind2, trouble, callActive;
	logic [7:0] maxAttempts, txData;
	logic [1:0] lineInUse, offHook, lineVoltage, lineFault;
	logic pulseDial, blindDial, accountEnable;
	logic [2:0] txFormat;
	logic [3:0] abnormalMask, systemState;
	logic [16:0] testMinutes;
	logic [63:0] primaryNumber, secondaryNumber;
	logic [2:0] hsFmt;
	logic [35:0] eventData;
	logic [7:0] syms[$];
	int miscompares, checksDone;
	alarm_dialer_sequencer #(.MS_CYCLES(MS)) u_alarm_dialer_sequencer (.core_clk(core_clk),
		.rst(rst), .twoLines(twoLines), .pulseDial(pulseDial), .blindDial(blindDial),
		.txFormat(txFormat), .maxAttempts(maxAttempts), .dialToneSec(8'h01),
		.waitSec(16'h0001), .testMinutes(testMinutes), .abnormalMask(abnormalMask),
		.accountNum(16'h0123), .userId(8'h41), .accountEnable(accountEnable),
		.primaryNumber(primaryNumber), .secondaryNumber(secondaryNumber),
		.systemState(systemState), .eventValid(eventValid), .eventReady(eventReady),
		.eventData(eventData), .lineInUse(lineInUse), .lineVoltage(lineVoltage),
		.dialTone(dialTone),
		.handshake(handshake), .handshakeFormat(hsFmt), .msgAck(msgAck),
		.shutdown(shutdown), .txValid(txValid), .txReady(txReady), .txData(txData),
		.offHook(offHook), .toneOn(toneOn), .toneDigit(), .line_one_indicator(ind1),
		.line_two_indicator(ind2), .trouble(trouble), .lineFault(lineFault),
		.callActive(callActive));
	station_model u_station_model (.core_clk(core_clk), .rst(rst), .answer(answer),
		.fmt(txFormat), .offHook(offHook), .toneOn(toneOn), .txValid(txValid),
		.dialTone(dialTone), .handshake(handshake), .handshakeFormat(hsFmt),
		.msgAck(msgAck), .shutdown(shutdown), .txReady(txReady));
	always @(posedge core_clk) if (txValid === 1'b1 && txReady === 1'b1) syms.push_back(txData);
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask
	task conclude;
		$display("checks %0d miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task report_two;
		int n, seize, lit, wrong;
		logic [63:0] exp;
		n = 0; seize = 0; lit = 0; wrong = 0;
		exp = 64'h3132_3339_3132_3335;
		twoLines = 1'b1; lineInUse = 2'h1; answer = 1'b1;
		repeat (3) @(negedge core_clk);
		eventValid = 1'b1;
		eventData = {4'h1, 12'h005, 8'h00, 12'h000};
		@(negedge core_clk);
		chk("ready second", 1, eventReady);
		eventData = {4'h7, 12'h009, 8'h00, 12'h000};
		@(negedge core_clk);
		eventValid = 1'b0;
		while (callActive !== 1'b0 || n < 100) begin
			@(negedge core_clk);
			n++;
			if (n > 20000) break;
			if (offHook === 2'h0 && syms.size() == 0) seize++;
			if (offHook[0] === 1'b1) wrong = 1;
			if (offHook === 2'h2 && syms.size() == 0 && ind2 === 1'b1) lit = 1;
		end
		chk("on hook hold", 1, seize >= 3000 * MS);
		chk("idle line chosen", 0, wrong);
		chk("steady indicator", 1, lit);
		chk("symbol count", 8, syms.size());
		for (int i = 0; i < 8 && i < syms.size(); i++) chk("symbol", exp[63-8*i -: 8], syms[i]);
		chk("indicator off", 0, ind2);
	endtask
	task exhaust;
		int n, extra;
		n = 0; extra = 0;
		twoLines = 1'b0; lineInUse = 2'h0; answer = 1'b0; eventValid = 1'b1;
		@(negedge core_clk);
		eventValid = 1'b0;
		while (trouble !== 1'b1 && n < 40000) begin
			@(negedge core_clk);
			n++;
		end
		chk("trouble raised", 1, trouble);
		repeat (100) begin
			@(negedge core_clk);
			if (trouble === 1'b1) extra++;
		end
		chk("single trouble", 0, extra);
	endtask
	task backup;
		accountEnable = 1'b0; lineVoltage = 2'h0; eventValid = 1'b1;
		repeat (20) @(negedge core_clk);
		chk("disabled intake", 0, callActive);
		chk("line fault", 1, lineFault);
		accountEnable = 1'b1; lineVoltage = 2'h3; eventValid = 1'b0;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (70000) @(posedge core_clk);
		miscompares++;
		conclude;
	end
	initial begin
		miscompares = 0; checksDone = 0; rst = 1'b1; twoLines = 1'b0; answer = 1'b0;
		maxAttempts = 8'h02; lineInUse = 2'h0; eventValid = 1'b0; eventData = 36'h0;
		pulseDial = 1'b0; blindDial = 1'b0; accountEnable = 1'b1; txFormat = 3'h2;
		abnormalMask = 4'h0; systemState = 4'h0; testMinutes = 17'h00000; lineVoltage = 2'h3;
		primaryNumber = 64'h12FF_FFFF_FFFF_FFFF; secondaryNumber = 64'h34FF_FFFF_FFFF_FFFF;
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
		report_two;
		exhaust;
		backup;
		conclude;
	end
endmodule
`default_nettype wire
